// ---- include/pt8_params.svh ----
// constants of the 8-bit period timer: register indices, fields, reset values, counts
`ifndef PT8_PARAMS_SVH
`define PT8_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PT8_IDX_IRQ_FLAGS 8'h0c
`define PT8_IDX_COUNTER 8'h11
`define PT8_IDX_CONTROL 8'h12
`define PT8_IDX_IRQ_MASK 8'h8c
`define PT8_IDX_PERIOD 8'h92

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PT8_CTL_PRE_LSB 0
`define PT8_CTL_PRE_MSB 1
`define PT8_CTL_RUN 2
`define PT8_CTL_POST_LSB 3
`define PT8_CTL_POST_MSB 6
`define PT8_CTL_IMPL 8'h7f
`define PT8_IRQ_MATCH_BIT 1
`define PT8_IRQ_IMPL 8'h02

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PT8_RST_COUNTER 8'h00
`define PT8_RST_CONTROL 8'h00
`define PT8_RST_PERIOD 8'hff
`define PT8_RST_IRQ 8'h00

// ----------------------------------------------------------------------------
// divider terminal counts (divide by limit plus one)
// ----------------------------------------------------------------------------
`define PT8_INSTR_LIMIT 4'h3
`define PT8_PRE_LIMIT_1 4'h0
`define PT8_PRE_LIMIT_4 4'h3
`define PT8_PRE_LIMIT_16 4'hf

`endif

// ---- include/pt8_pkg.sv ----
// types shared by the 8-bit period timer modules
package pt8_pkg;

  // state of one small modulo divider
  typedef struct packed {
    logic [3:0] count;
  } pt8_div_s;

  // time base handed to the pwm unit
  typedef struct packed {
    logic [7:0] time_base;
    logic period_match;
  } pt8_pwm_s;

  // complete state of the timer top
  typedef struct packed {
    logic [7:0] counter;
    logic [7:0] period;
    logic [7:0] control;
    logic [7:0] irq_flags;
    logic [7:0] irq_mask;
    logic ack;
    logic [7:0] rdata;
    logic match_out;
  } pt8_state_s;

endpackage : pt8_pkg

// ---- rtl/pt8_div.sv ----
// modulo divider with synchronous clear, used for the clock, pre- and postscaler
`timescale 1ns/1ps
`include "pt8_params.svh"

module pt8_div (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic clear,
  input wire logic [3:0] limit,
  output logic [3:0] count,
  output logic tc
);

  pt8_pkg::pt8_div_s st_r;
  pt8_pkg::pt8_div_s st_nxt;

  // clear wins over a tick so a cleared divider never fires in that cycle
  assign tc = tick & ~clear & (st_r.count >= limit);
  assign count = st_r.count;

  // next count: clear, wrap at the limit, or advance on a tick
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.count = 4'h0;
    end else if (tc) begin
      st_nxt.count = 4'h0; // >= also recovers if the limit dropped below the count
    end else if (tick) begin
      st_nxt.count = st_r.count + 4'h1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : pt8_div

// ---- rtl/pt8_timer.sv ----
// 8-bit period timer with pre/postscaler, wishbone register slave and match interrupt
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "pt8_params.svh"

// Contract
// - The counter counts up from zero and wraps to zero on the tick after it equals the period.
// - The count tick is clock/4, then divided by 1, 4 or 16 for prescale 00, 01 or 1x.
// - A 4-bit postscaler divides matches by setting plus one; its end count sets the flag.
// - The postscaled match is latched in the match flag, bit one of the interrupt flags.
// - The counter runs only while the run bit, control bit two, is one.
// - Prescaler and postscaler counts clear on a counter write, a control write and any reset.
// - A control write leaves the counter value unchanged.
// - The counter is readable and writable and clears to zero on reset.
// - The period register is readable and writable and loads all ones on reset.
// - The raw match pulse, ahead of the postscaler, goes to the serial port as a shift clock.
// - The counter and its period match are offered to the pwm unit as its time base.
module pt8_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic sync_serial_port_shift_tick,
  output pt8_pkg::pt8_pwm_s capture_compare_pwm_unit_base
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // register hit on a word index
  function automatic logic pt8_hit(input logic [7:0] idx, input logic [7:0] target);
    pt8_hit = (idx == target);
  endfunction : pt8_hit

  // --------------------------------------------------------------------------
  // state and bus decode
  // --------------------------------------------------------------------------

  pt8_pkg::pt8_state_s st_r;
  pt8_pkg::pt8_state_s st_nxt;

  logic bus_req;
  logic bus_commit;
  logic [7:0] bus_idx;
  logic wr_lane;
  logic wr_counter;
  logic wr_control;
  logic wr_period;
  logic wr_mask;
  logic rd_flags;
  logic scaler_clr;
  logic timer_run;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic [3:0] pre_limit;
  logic instr_tick;
  logic pre_tc;
  logic post_tc;
  logic inc_en;
  logic match_evt;
  logic [3:0] pre_count;
  logic [3:0] post_count;
  logic [3:0] instr_count;

  // a request is taken when ack is high; writes and read side effects happen there
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_commit = bus_req & st_r.ack;
  assign bus_idx = wb_adr_i[9:2];
  assign wr_lane = bus_commit & wb_we_i & wb_sel_i[0];
  assign wr_counter = wr_lane & pt8_hit(bus_idx, `PT8_IDX_COUNTER);
  assign wr_control = wr_lane & pt8_hit(bus_idx, `PT8_IDX_CONTROL);
  assign wr_period = wr_lane & pt8_hit(bus_idx, `PT8_IDX_PERIOD);
  assign wr_mask = wr_lane & pt8_hit(bus_idx, `PT8_IDX_IRQ_MASK);
  assign rd_flags = bus_commit & ~wb_we_i & pt8_hit(bus_idx, `PT8_IDX_IRQ_FLAGS);

  // control fields
  assign timer_run = st_r.control[`PT8_CTL_RUN];
  assign prescale_select = st_r.control[`PT8_CTL_PRE_MSB:`PT8_CTL_PRE_LSB];
  assign postscale_select = st_r.control[`PT8_CTL_POST_MSB:`PT8_CTL_POST_LSB];

  // both scalers restart on these writes; reset is handled inside the dividers
  assign scaler_clr = wr_counter | wr_control;

  // prescale limit: 00 -> /1, 01 -> /4, 1x -> /16
  always_comb begin
    if (prescale_select[1]) begin
      pre_limit = `PT8_PRE_LIMIT_16;
    end else if (prescale_select[0]) begin
      pre_limit = `PT8_PRE_LIMIT_4;
    end else begin
      pre_limit = `PT8_PRE_LIMIT_1;
    end
  end

  // --------------------------------------------------------------------------
  // clock chain: instruction tick, prescaler, postscaler
  // --------------------------------------------------------------------------

  // instruction tick every fourth clock, free running
  pt8_div u_instr (
    .clk(clk),
    .reset(reset),
    .tick(1'b1),
    .clear(1'b0),
    .limit(`PT8_INSTR_LIMIT),
    .count(instr_count),
    .tc(instr_tick)
  );

  // prescaler only advances while running, so a stopped timer burns no ticks
  pt8_div u_pre (
    .clk(clk),
    .reset(reset),
    .tick(instr_tick & timer_run),
    .clear(scaler_clr),
    .limit(pre_limit),
    .count(pre_count),
    .tc(pre_tc)
  );

  // a software counter write takes precedence over a coincident increment
  assign inc_en = pre_tc & ~wr_counter;
  assign match_evt = inc_en & (st_r.counter == st_r.period);

  // postscaler counts matches; setting n gives a flag every n+1 matches
  pt8_div u_post (
    .clk(clk),
    .reset(reset),
    .tick(match_evt),
    .clear(scaler_clr),
    .limit(postscale_select),
    .count(post_count),
    .tc(post_tc)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------

  always_comb begin
    st_nxt = st_r;
    // counter: write first, then wrap or increment
    if (wr_counter) begin
      st_nxt.counter = wb_dat_i[7:0];
    end else if (match_evt) begin
      st_nxt.counter = 8'h00;
    end else if (inc_en) begin
      st_nxt.counter = st_r.counter + 8'h01;
    end
    // control write keeps the counter, only restarts the scalers
    if (wr_control) begin
      st_nxt.control = wb_dat_i[7:0] & `PT8_CTL_IMPL;
    end
    if (wr_period) begin
      st_nxt.period = wb_dat_i[7:0];
    end
    if (wr_mask) begin
      st_nxt.irq_mask = wb_dat_i[7:0] & `PT8_IRQ_IMPL;
    end
    // flags: clear only the bits that the read returned, then set wins
    st_nxt.irq_flags = st_r.irq_flags & ~(rd_flags ? st_r.rdata : 8'h00);
    if (post_tc) begin
      st_nxt.irq_flags[`PT8_IRQ_MATCH_BIT] = 1'b1;
    end
    // raw match pulse for the serial port and pwm, one clock wide
    st_nxt.match_out = match_evt;
    // bus: ack one cycle after the request, dropped after the commit edge
    st_nxt.ack = bus_req & ~st_r.ack;
    if (bus_req & ~st_r.ack) begin
      unique case (bus_idx)
        `PT8_IDX_COUNTER: st_nxt.rdata = st_r.counter;
        `PT8_IDX_CONTROL: st_nxt.rdata = st_r.control;
        `PT8_IDX_PERIOD: st_nxt.rdata = st_r.period;
        `PT8_IDX_IRQ_FLAGS: st_nxt.rdata = st_r.irq_flags;
        `PT8_IDX_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
        default: st_nxt.rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // state register; reset also clears the scalers inside the dividers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.counter <= `PT8_RST_COUNTER;
      st_r.period <= `PT8_RST_PERIOD;
      st_r.control <= `PT8_RST_CONTROL;
      st_r.irq_flags <= `PT8_RST_IRQ;
      st_r.irq_mask <= `PT8_RST_IRQ;
      st_r.ack <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.match_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------

  // narrow data in the low lane, upper bits read zero
  assign wb_dat_o = {24'h000000, st_r.rdata};
  assign wb_ack_o = st_r.ack;
  assign irq_o = |(st_r.irq_flags & st_r.irq_mask);
  assign sync_serial_port_shift_tick = st_r.match_out;
  // pwm sees the live counter and the registered match strobe
  assign capture_compare_pwm_unit_base.time_base = st_r.counter;
  assign capture_compare_pwm_unit_base.period_match = st_r.match_out;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------

  a_count_wrap: assert property (@(posedge clk) disable iff (reset)
    inc_en && (st_r.counter == st_r.period) |=> st_r.counter == 8'h00)
    else $error("counter did not wrap to zero after period match");

  a_count_step: assert property (@(posedge clk) disable iff (reset)
    inc_en && (st_r.counter != st_r.period) |=> st_r.counter == $past(st_r.counter) + 8'h01)
    else $error("counter did not advance by one");

  a_prescale_one: assert property (@(posedge clk) disable iff (reset)
    timer_run && (prescale_select == 2'b00) && !scaler_clr && instr_tick |-> pre_tc)
    else $error("prescale 1 did not pass the instruction tick");

  a_prescale_sixteen: assert property (@(posedge clk) disable iff (reset)
    pre_tc && prescale_select[1] |-> pre_count == 4'hf)
    else $error("prescale 16 fired at the wrong count");

  a_instr_quarter: assert property (@(posedge clk) disable iff (reset)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick is not every fourth clock");

  a_post_direct: assert property (@(posedge clk) disable iff (reset)
    match_evt && (postscale_select == 4'h0) |-> post_tc)
    else $error("postscale 1 did not pass the match");

  a_flag_set: assert property (@(posedge clk) disable iff (reset)
    post_tc |=> st_r.irq_flags[`PT8_IRQ_MATCH_BIT])
    else $error("postscaler terminal count did not set the match flag");

  a_stop_hold: assert property (@(posedge clk) disable iff (reset)
    !timer_run && !wr_counter |=> $stable(st_r.counter))
    else $error("counter moved while stopped");

  a_stop_nomatch: assert property (@(posedge clk) disable iff (reset)
    !timer_run |-> !match_evt)
    else $error("match produced while stopped");

  a_scaler_clear: assert property (@(posedge clk) disable iff (reset)
    scaler_clr |=> (pre_count == 4'h0) && (post_count == 4'h0))
    else $error("scalers not cleared by a counter or control write");

  a_ctrl_keep: assert property (@(posedge clk) disable iff (reset)
    wr_control |=> st_r.counter == $past(st_r.counter))
    else $error("control write changed the counter");

  a_reset_vals: assert property (@(posedge clk)
    reset |=> (st_r.period == 8'hff) && (st_r.counter == 8'h00) && (pre_count == 4'h0))
    else $error("wrong values after reset");

  a_cnt_write: assert property (@(posedge clk) disable iff (reset)
    wr_counter |=> st_r.counter == $past(wb_dat_i[7:0]))
    else $error("counter write not stored");

  a_shift_tick: assert property (@(posedge clk) disable iff (reset)
    match_evt |=> sync_serial_port_shift_tick ##1 !sync_serial_port_shift_tick || match_evt)
    else $error("serial port tick did not follow the match");

  a_pwm_base: assert property (@(posedge clk) disable iff (reset)
    capture_compare_pwm_unit_base.period_match |-> capture_compare_pwm_unit_base.time_base == 8'h00
      || $past(wr_counter))
    else $error("pwm match not paired with a zeroed time base");

  a_bus_ack: assert property (@(posedge clk) disable iff (reset)
    bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given in the cycle after the request");

  a_instr_phase: assert property (@(posedge clk) disable iff (reset)
    instr_tick |-> instr_count == `PT8_INSTR_LIMIT)
    else $error("instruction tick at the wrong divider count");

  a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    $fell(st_r.irq_flags[`PT8_IRQ_MATCH_BIT]) |-> $past(rd_flags))
    else $error("match flag dropped without a flag read");

  a_run_gate: assert property (@(posedge clk) disable iff (reset)
    !timer_run |-> !pre_tc)
    else $error("prescaler fired while stopped");

  a_lane_ignore: assert property (@(posedge clk) disable iff (reset)
    bus_commit && wb_we_i && !wb_sel_i[0] |=> $stable(st_r.period) && $stable(st_r.control))
    else $error("write with the low lane off changed a register");

endmodule : pt8_timer

// ---- sim/pt8_timer_tb_top.sv ----
// self-checking testbench of the 8-bit period timer
`timescale 1ns/1ps
`include "pt8_params.svh"

module pt8_timer_tb_top;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [3:0] wsel = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic irq;
  logic tick;
  pt8_pkg::pt8_pwm_s base;
  int mismatches = 0;
  int samples_checked = 0;
  longint tick_q[$];
  logic [7:0] rd;
  logic [7:0] per;
  logic [7:0] cv;
  int div;
  int ps;
  int n;
  longint t0;

  // 40 mhz clock
  always #12.5 clk = ~clk;

  pt8_timer u_dut (
    .clk(clk),
    .reset(reset),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat_i),
    .wb_dat_o(dat_o),
    .wb_ack_o(ack),
    .irq_o(irq),
    .sync_serial_port_shift_tick(tick),
    .capture_compare_pwm_unit_base(base)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= wsel;
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk("ack", 32'h1, {31'h0, ack});
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(nm, {24'h0, exp}, {24'h0, rd});
  endtask : rchk

  // bounded wait for a number of raw match pulses
  task automatic wait_ticks(input int k);
    n = 0;
    while (tick_q.size() < k && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("ticks seen", 32'h1, {31'h0, tick_q.size() >= k});
  endtask : wait_ticks

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // --------------------------------------------------------------------------
  // match monitor: the pwm base must carry the same pulse as the shift tick
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (tick === 1'b1) begin
      tick_q.push_back($time);
      chk("pwm match", 32'h1, {31'h0, base.period_match});
      chk("base at wrap", 32'h0, {24'h0, base.time_base});
    end
  end

  // watchdog; the whole run needs well under a fifth of this span
  initial begin
    #1_000_000;
    mismatches++;
    conclude();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h2b6bace7));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped index
    rchk("counter", `PT8_IDX_COUNTER, `PT8_RST_COUNTER);
    rchk("control", `PT8_IDX_CONTROL, `PT8_RST_CONTROL);
    rchk("period", `PT8_IDX_PERIOD, `PT8_RST_PERIOD);
    rchk("flags", `PT8_IDX_IRQ_FLAGS, 8'h00);
    rchk("mask", `PT8_IDX_IRQ_MASK, 8'h00);
    rchk("unmapped", 8'h40, 8'h00);
    // random register contents; control write keeps the counter
    per = 8'($urandom());
    cv = 8'($urandom());
    wb(1'b1, `PT8_IDX_PERIOD, per);
    rchk("period rw", `PT8_IDX_PERIOD, per);
    wb(1'b1, `PT8_IDX_COUNTER, cv);
    rchk("counter rw", `PT8_IDX_COUNTER, cv);
    wb(1'b1, `PT8_IDX_CONTROL, 8'hfb);
    rchk("control rw", `PT8_IDX_CONTROL, 8'h7b);
    rchk("counter kept", `PT8_IDX_COUNTER, cv);
    // a write with the low lane off and a write to the flags are both ignored
    wsel = 4'he;
    wb(1'b1, `PT8_IDX_PERIOD, ~per);
    wsel = 4'hf;
    rchk("period lane off", `PT8_IDX_PERIOD, per);
    wb(1'b1, `PT8_IDX_IRQ_FLAGS, 8'h02);
    rchk("flags read only", `PT8_IDX_IRQ_FLAGS, 8'h00);
    // stopped timer holds its count and makes no match
    repeat (100) @(posedge clk);
    rchk("counter held", `PT8_IDX_COUNTER, cv);
    chk("base held", {24'h0, cv}, {24'h0, base.time_base});
    chk("no match stopped", 32'h0, 32'(tick_q.size()));
    // match spacing for every prescale code
    for (int p = 0; p < 4; p++) begin
      per = 8'($urandom_range(1, 6));
      div = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wb(1'b1, `PT8_IDX_CONTROL, 8'h00);
      wb(1'b1, `PT8_IDX_PERIOD, per);
      wb(1'b1, `PT8_IDX_COUNTER, 8'h00);
      tick_q.delete();
      wb(1'b1, `PT8_IDX_CONTROL, 8'(4 + p));
      wait_ticks(3);
      chk("interval", 32'((per + 1) * div * 4 * 25), 32'(tick_q[2] - tick_q[1]));
    end
    // counter write mid-run restarts the prescaler from zero
    wb(1'b1, `PT8_IDX_PERIOD, 8'h03);
    wb(1'b1, `PT8_IDX_CONTROL, 8'h06);
    repeat ($urandom_range(20, 200)) @(posedge clk);
    wb(1'b1, `PT8_IDX_COUNTER, 8'h00);
    t0 = $time;
    // a pulse from a match just before the write may land in this very step
    @(posedge clk);
    tick_q.delete();
    wait_ticks(1);
    n = int'((tick_q[0] - t0) / 25);
    chk("restart delay ok", 32'h1, {31'h0, n >= 250 && n <= 260});
    // postscaler terminal count, flag, mask and read clear
    for (int i = 0; i < 3; i++) begin
      ps = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(1, 14);
      wb(1'b1, `PT8_IDX_CONTROL, 8'h00);
      wb(1'b1, `PT8_IDX_PERIOD, 8'h01);
      wb(1'b1, `PT8_IDX_COUNTER, 8'h00);
      wb(1'b0, `PT8_IDX_IRQ_FLAGS, 8'h00);
      wb(1'b1, `PT8_IDX_IRQ_MASK, 8'h02);
      tick_q.delete();
      wb(1'b1, `PT8_IDX_CONTROL, 8'(ps << 3) | 8'h04);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
        @(posedge clk);
        #1;
        n++;
      end
      @(posedge clk);
      #1;
      chk("post count", 32'(ps + 1), 32'(tick_q.size()));
      wb(1'b1, `PT8_IDX_CONTROL, 8'h00);
      wb(1'b1, `PT8_IDX_IRQ_MASK, 8'h00);
      #1;
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, `PT8_IDX_IRQ_MASK, 8'h02);
      #1;
      chk("irq unmasked", 32'h1, {31'h0, irq});
      rchk("flag set", `PT8_IDX_IRQ_FLAGS, 8'h02);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      rchk("flag clear", `PT8_IDX_IRQ_FLAGS, 8'h00);
    end
    // reset in mid-run, held long enough that no flag history leaks across it
    wb(1'b1, `PT8_IDX_PERIOD, 8'h05);
    wb(1'b1, `PT8_IDX_CONTROL, 8'h04);
    repeat ($urandom_range(10, 40)) @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk("counter reset", `PT8_IDX_COUNTER, `PT8_RST_COUNTER);
    rchk("period reset", `PT8_IDX_PERIOD, `PT8_RST_PERIOD);
    rchk("control reset", `PT8_IDX_CONTROL, `PT8_RST_CONTROL);
    rchk("mask reset", `PT8_IDX_IRQ_MASK, `PT8_RST_IRQ);
    chk("irq after reset", 32'h0, {31'h0, irq});
    conclude();
  end
endmodule : pt8_timer_tb_top
